// ---- dac_control_register_set.sv ----
// register core of the converter control: config, clear code, triggers, status
// assumes pins arrive unsynchronised; serial clock only runs inside frames
`timescale 1ns/10ps
module dac_control_register_set
   import dac_ctrl_pkg::*;
#(
   parameter int CAL_CYCLES = `CAL_CYCLES_DEFAULT
)
(
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_sclk,
   input wire logic i_sync_n,
   input wire logic i_sdi,
   input wire logic i_clear_input_n,
   input wire logic i_load_strobe_n,
   output logic o_sdo,
   output logic o_sdo_oe_n,
   output logic o_alarm_out,
   output logic o_alarm_oe_n,
   output logic o_fast_readout_enable,
   output logic o_settling_mode_select,
   output logic [3:0] o_reference_span_select,
   output logic o_power_down_control,
   output logic o_temperature_cal_enable,
   output logic [1:0] o_track_hold_mask,
   output logic o_track_hold_disable,
   output logic [1:0] o_update_rate,
   output logic o_update_source_select,
   output logic [7:0] o_clear_code,
   output logic o_clear_mode,
   output logic o_output_update,
   output logic o_recalibration_done_flag
);
   `include "dac_ctrl_params.svh"

   localparam int CW = $clog2(CAL_CYCLES + 1);
   localparam int CAL_MAX = CAL_CYCLES + 2;
   // a literal cannot be bit-selected, so the reset word gets a name
   localparam logic [23:0] CFG1_INIT = `CFG1_RESET;

   generate
      if (CAL_CYCLES < 1)
         $error("CAL_CYCLES must be at least one");
   endgenerate

   function automatic logic wr_hit(input frame_t f, input logic [6:0] a);
      wr_hit = ~f.dir & (f.addr == a);
   endfunction : wr_hit

   function automatic logic span_valid(input logic [3:0] code);
      span_valid = (code >= `SPAN_MIN_VALID);
   endfunction : span_valid

   ////////////////////////////////////////////////////////////////////////////
   // link side

   frame_t rx_frame;
   frame_t tx_frame_reg;
   logic rx_toggle;

   frame_link u_link
   (
      .i_sclk(i_sclk),
      .i_sync_n(i_sync_n),
      .i_sdi(i_sdi),
      .i_tx_frame(tx_frame_reg),
      .o_rx_frame(rx_frame),
      .o_rx_toggle(rx_toggle),
      .o_sdo(o_sdo)
   );

   ////////////////////////////////////////////////////////////////////////////
   // synchronisers

   logic sync_meta_reg, sync_s2_reg, sync_s3_reg;
   logic tog_meta_reg, tog_s2_reg, tog_last_reg;
   logic clr_meta_reg, clr_s2_reg;
   logic ld_meta_reg, ld_s2_reg, ld_s3_reg;

   always_ff @(posedge i_clock)
   begin
      sync_meta_reg <= i_sync_n;
      sync_s2_reg <= sync_meta_reg;
      sync_s3_reg <= sync_s2_reg;
      tog_meta_reg <= rx_toggle;
      tog_s2_reg <= tog_meta_reg;
      tog_last_reg <= tog_s2_reg;
      clr_meta_reg <= i_clear_input_n;
      clr_s2_reg <= clr_meta_reg;
      ld_meta_reg <= i_load_strobe_n;
      ld_s2_reg <= ld_meta_reg;
      ld_s3_reg <= ld_s2_reg;
   end

   // toggle edge means a whole word sits steady in rx_frame
   wire word_evt = i_nrst & (tog_s2_reg ^ tog_last_reg);
   wire frame_end = sync_s2_reg & ~sync_s3_reg;
   wire ld_fall = ~ld_s2_reg & ld_s3_reg;
   wire clr_active = ~clr_s2_reg;

   ////////////////////////////////////////////////////////////////////////////
   // frame decode

   logic soft_reset_reg;
   logic word_pending_reg;
   wire rst_all = ~i_nrst | soft_reset_reg; // RULE9
   wire apply = frame_end & (word_pending_reg | word_evt);
   wire wr = apply & ~rx_frame.dir; // RULE16
   wire rd = apply & rx_frame.dir; // RULE16
   wire wr_cfg1 = apply & wr_hit(rx_frame, `ADDR_CFG1);
   wire wr_clear = apply & wr_hit(rx_frame, `ADDR_CLEAR);
   wire wr_trig = apply & wr_hit(rx_frame, `ADDR_TRIG);
   wire wr_cfg2 = apply & wr_hit(rx_frame, `ADDR_CFG2);
   // status is never a write target; such frames store nothing but still leave clear mode
   wire rd_stat = rd & (rx_frame.addr == `ADDR_STAT); // RULE11

   always_ff @(posedge i_clock)
   begin
      if (!i_nrst || frame_end)
         word_pending_reg <= 1'b0;
      else if (word_evt)
         word_pending_reg <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers

   logic [23:0] cfg1_reg, cfg1_next;
   logic [23:0] cfg2_reg, clear_reg;
   wire [23:0] cfg1_written = (cfg1_reg & ~`CFG1_WMASK) | (rx_frame.data & `CFG1_WMASK);
   wire span_ok = span_valid(rx_frame.data[`SPAN_HI:`SPAN_LO]);
   // mask only moves in fast settling with track and hold running
   wire mask_open = ~cfg1_reg[`BIT_SETTLING] & ~cfg2_reg[`BIT_TH_DISABLE]; // RULE19
   wire [23:0] cfg2_written = (cfg2_reg & ~`CFG2_WMASK) | (rx_frame.data & `CFG2_WMASK);
   wire [23:0] clear_written = rx_frame.data & `CLEAR_WMASK; // RULE7

   always_comb
   begin
      cfg1_next = cfg1_reg;
      if (wr_cfg1)
      begin
         cfg1_next = cfg1_written; // RULE1 RULE2 RULE4 RULE6 RULE18
         // invalid span codes leave the old span in place
         if (!span_ok)
            cfg1_next[`SPAN_HI:`SPAN_LO] = cfg1_reg[`SPAN_HI:`SPAN_LO]; // RULE5
         if (mask_open)
            cfg1_next[`MASK_HI:`MASK_LO] = rx_frame.data[`MASK_HI:`MASK_LO]; // RULE19
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (rst_all)
      begin
         cfg1_reg <= `CFG1_RESET; // RULE1 RULE3 RULE4 RULE6
         cfg2_reg <= `CFG2_RESET; // RULE14
         clear_reg <= `CLEAR_RESET;
         o_sdo_oe_n <= ~CFG1_INIT[`BIT_SDO_EN];
      end
      else
      begin
         cfg1_reg <= cfg1_next;
         o_sdo_oe_n <= ~cfg1_next[`BIT_SDO_EN]; // RULE3
         if (wr_cfg2)
            cfg2_reg <= cfg2_written; // RULE14 RULE15
         if (wr_clear)
            clear_reg <= clear_written; // RULE7
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // triggers, clear mode and output update

   wire sdo_en = cfg1_reg[`BIT_SDO_EN];
   wire trig_now = word_evt & wr_hit(rx_frame, `ADDR_TRIG);
   // serial output on: act at the 32nd bit, else at sync rising
   wire soft_clear_evt = sdo_en ? (trig_now & rx_frame.data[`BIT_SOFT_CLEAR])
                                : (wr_trig & rx_frame.data[`BIT_SOFT_CLEAR]); // RULE10
   wire recal_start = wr_trig & rx_frame.data[`BIT_RECAL]; // RULE8
   wire data_now = word_evt & wr_hit(rx_frame, `ADDR_DATA);
   wire data_end = apply & wr_hit(rx_frame, `ADDR_DATA);
   wire update_evt = cfg1_reg[`BIT_UPDATE_SRC] ? ld_fall : (sdo_en ? data_now : data_end); // RULE18
   wire clear_exit = wr & ~(wr_trig & rx_frame.data[`BIT_SOFT_CLEAR]);

   always_ff @(posedge i_clock)
   begin
      if (rst_all)
      begin
         soft_reset_reg <= 1'b0;
         o_clear_mode <= 1'b0;
         o_output_update <= 1'b0;
      end
      else
      begin
         soft_reset_reg <= wr_trig & rx_frame.data[`BIT_SOFT_RESET]; // RULE9
         o_output_update <= update_evt;
         // entering wins over leaving in the same cycle
         if (clr_active || soft_clear_evt)
            o_clear_mode <= 1'b1; // RULE7 RULE10
         else if (clear_exit)
            o_clear_mode <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // temperature recalibration and alarm

   cal_state_t cal_state_reg;
   logic [CW-1:0] cal_count_reg;
   logic alarm_oe_n_reg;
   wire cal_finish = (cal_state_reg == CAL_BUSY) & (cal_count_reg == '0);
   wire alarm_fire = cal_finish & cfg1_reg[`BIT_ALARM_EN]; // RULE2

   always_ff @(posedge i_clock)
   begin
      if (rst_all)
      begin
         cal_state_reg <= CAL_IDLE;
         cal_count_reg <= '0;
         o_recalibration_done_flag <= 1'b0;
      end
      else
      begin
         case (cal_state_reg)
            CAL_IDLE:
            begin
               if (recal_start)
               begin
                  cal_state_reg <= CAL_BUSY; // RULE8
                  cal_count_reg <= CW'(CAL_CYCLES - 1);
                  o_recalibration_done_flag <= 1'b0; // RULE12
               end
            end
            CAL_BUSY:
            begin
               if (cal_finish)
               begin
                  cal_state_reg <= CAL_IDLE;
                  o_recalibration_done_flag <= 1'b1; // RULE8 RULE12
               end
               else
                  cal_count_reg <= cal_count_reg - 1'b1;
            end
            default:
               cal_state_reg <= CAL_IDLE;
         endcase
      end
   end

   // alarm pin is open drain: driven low only while oe is low
   always_ff @(posedge i_clock)
   begin
      if (rst_all)
         alarm_oe_n_reg <= 1'b1;
      else if (alarm_fire)
         alarm_oe_n_reg <= 1'b0; // RULE2 RULE8
      else if (rd_stat)
         alarm_oe_n_reg <= 1'b1; // RULE13
   end

   always_ff @(posedge i_clock)
   begin
      o_alarm_out <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // readback for the next frame

   wire [23:0] status_word = {11'h000, o_recalibration_done_flag, 12'h000}; // RULE12
   wire [23:0] read_data =
      (rx_frame.addr == `ADDR_CFG1) ? cfg1_reg :
      (rx_frame.addr == `ADDR_CLEAR) ? clear_reg :
      (rx_frame.addr == `ADDR_STAT) ? status_word :
      (rx_frame.addr == `ADDR_CFG2) ? cfg2_reg : 24'h00_0000;

   always_ff @(posedge i_clock)
   begin
      if (rst_all)
         tx_frame_reg <= '0;
      else if (rd)
         tx_frame_reg <= {1'b1, rx_frame.addr, read_data}; // RULE16
      else if (wr)
         tx_frame_reg <= '0;
   end

   assign o_alarm_oe_n = alarm_oe_n_reg;
   assign o_fast_readout_enable = cfg1_reg[`BIT_FAST_READOUT]; // RULE1
   assign o_settling_mode_select = cfg1_reg[`BIT_SETTLING]; // RULE4
   assign o_reference_span_select = cfg1_reg[`SPAN_HI:`SPAN_LO];
   assign o_power_down_control = cfg1_reg[`BIT_POWER_DOWN]; // RULE6
   assign o_temperature_cal_enable = cfg1_reg[`BIT_TEMP_CAL_EN];
   assign o_track_hold_mask = cfg1_reg[`MASK_HI:`MASK_LO];
   assign o_update_source_select = cfg1_reg[`BIT_UPDATE_SRC];
   assign o_track_hold_disable = cfg2_reg[`BIT_TH_DISABLE]; // RULE14
   assign o_update_rate = cfg2_reg[`RATE_HI:`RATE_LO]; // RULE15
   assign o_clear_code = clear_reg[`CLEAR_HI:`CLEAR_LO]; // RULE7

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_nrst);

   a_cfg1_reset_value: assert property ($rose(i_nrst) |-> cfg1_reg == `CFG1_RESET) // RULE4
      else $error("primary_config not at reset value after reset");
   a_sdo_enable_pin: assert property (o_sdo_oe_n != cfg1_reg[`BIT_SDO_EN]) // RULE3
      else $error("serial output enable pin disagrees with register");
   a_alarm_needs_enable: assert property ($fell(alarm_oe_n_reg) |-> $past(cfg1_reg[`BIT_ALARM_EN])) // RULE2
      else $error("alarm driven while alarm output disabled");
   a_alarm_read_release: assert property (rd_stat && !alarm_fire && !soft_reset_reg |=> alarm_oe_n_reg) // RULE13
      else $error("status read did not release alarm");
   a_recal_completes: assert property (recal_start && cal_state_reg == CAL_IDLE && !soft_reset_reg
                                       |=> !o_recalibration_done_flag ##[1:CAL_MAX] o_recalibration_done_flag) // RULE8
      else $error("recalibration did not complete in time");
   a_flag_while_busy: assert property (cal_state_reg == CAL_BUSY |-> !o_recalibration_done_flag) // RULE12
      else $error("done flag set during recalibration");
   a_span_stays_valid: assert property (span_valid(cfg1_reg[`SPAN_HI:`SPAN_LO])) // RULE5
      else $error("invalid reference span stored");
   a_mask_locked_hold: assert property ((cfg1_reg[`BIT_SETTLING] || cfg2_reg[`BIT_TH_DISABLE]) && !soft_reset_reg
                                        |=> $stable(cfg1_reg[`MASK_HI:`MASK_LO])) // RULE19
      else $error("track hold mask changed while locked");
   a_soft_reset_defaults: assert property (soft_reset_reg |=> cfg2_reg == `CFG2_RESET && clear_reg == `CLEAR_RESET
                                           && cfg1_reg == `CFG1_RESET) // RULE9
      else $error("software reset did not restore defaults");
   a_soft_clear_enter: assert property (soft_clear_evt && !soft_reset_reg |=> o_clear_mode) // RULE10
      else $error("software clear did not enter clear mode");
   a_rate_write_path: assert property (wr_cfg2 && !soft_reset_reg
                                       |=> o_update_rate == $past(rx_frame.data[`RATE_HI:`RATE_LO])) // RULE15
      else $error("update rate write not stored");
   a_update_on_strobe: assert property (o_output_update && $past(cfg1_reg[`BIT_UPDATE_SRC]) |-> $past(ld_fall)) // RULE18
      else $error("update without load strobe in synchronous mode");
   a_update_from_data: assert property (o_output_update && !$past(cfg1_reg[`BIT_UPDATE_SRC])
                                        |-> $past(data_now || data_end)) // RULE18
      else $error("update without data write in asynchronous mode");
   a_clear_pin_enter: assert property (clr_active && !soft_reset_reg |=> o_clear_mode) // RULE7
      else $error("clear pin did not enter clear mode");
   a_clear_write_exit: assert property (clear_exit && !clr_active && !soft_clear_evt && !soft_reset_reg
                                        |=> !o_clear_mode) // RULE7
      else $error("write did not leave clear mode");
   a_done_after_finish: assert property (cal_finish && !soft_reset_reg |=> o_recalibration_done_flag) // RULE12
      else $error("done flag not set at end of recalibration");

endmodule : dac_control_register_set

// ---- dac_ctrl_params.svh ----
// constants of the dac control register set: addresses, fields, reset values
// assumes inclusion by the package and by both design modules
// Overview of operation
// RULE1 - primary_config bit 13 enables fast readout
// RULE2 - primary_config bit 12 lets alarm pin pull low
// RULE3 - primary_config bit 11 enables serial output, reset 1
// RULE4 - primary_config bit 10: 0 fast settling, 1 low distortion
// RULE5 - span codes 0000 and 0001 are invalid
// RULE6 - primary_config bit 4 powers the converter down
// RULE7 - clear code sits in bits 23-16
// RULE8 - trigger bit 8 starts recalibration, sets done flag
// RULE9 - trigger bit 6 resets the whole device
// RULE10 - trigger bit 5 enters clear mode
// RULE11 - host only reads the status register
// RULE12 - done flag 0 while busy, 1 after
// RULE13 - status readback releases the alarm pin
// RULE14 - secondary_config bit 7 disables track and hold
// RULE15 - secondary_config bits 5-4 select update rate
// RULE16 - bit 31 direction, bits 30-24 address
// RULE17 - 32-bit frames, capture falling, drive rising
// RULE18 - primary_config bit 14 selects update source
// RULE19 - track hold mask writable only when unlocked
// RULE20 - host writes reserved fields with reset values
`ifndef DAC_CTRL_PARAMS_SVH
`define DAC_CTRL_PARAMS_SVH
`define ADDR_DATA 7'h01
`define ADDR_CFG1 7'h02
`define ADDR_CLEAR 7'h03
`define ADDR_TRIG 7'h04
`define ADDR_STAT 7'h05
`define ADDR_CFG2 7'h06
`define CFG1_RESET 24'h00_4c80
`define CFG1_WMASK 24'h80_7fd0
`define CFG2_RESET 24'h00_0040
`define CFG2_WMASK 24'h00_00b0
`define CLEAR_RESET 24'h00_0000
`define CLEAR_WMASK 24'hff_0000
`define BIT_TEMP_CAL_EN 23
`define MASK_HI 19
`define MASK_LO 18
`define BIT_UPDATE_SRC 14
`define BIT_FAST_READOUT 13
`define BIT_ALARM_EN 12
`define BIT_SDO_EN 11
`define BIT_SETTLING 10
`define SPAN_HI 9
`define SPAN_LO 6
`define BIT_POWER_DOWN 4
`define BIT_RECAL 8
`define BIT_SOFT_RESET 6
`define BIT_SOFT_CLEAR 5
`define BIT_DONE_FLAG 12
`define BIT_TH_DISABLE 7
`define RATE_HI 5
`define RATE_LO 4
`define CLEAR_HI 23
`define CLEAR_LO 16
`define SPAN_MIN_VALID 4'h2
`define FRAME_LAST_BIT 5'h1f
`define CAL_CYCLES_DEFAULT 32'h0000_0040
`endif

// ---- dac_ctrl_pkg.sv ----
// types shared by the link shifter and the register core
// assumes the constants header sits in the same folder
`include "dac_ctrl_params.svh"
package dac_ctrl_pkg;

   typedef struct packed
   {
      logic dir;
      logic [6:0] addr;
      logic [23:0] data;
   } frame_t;

   typedef enum logic {CAL_IDLE, CAL_BUSY} cal_state_t;

endpackage : dac_ctrl_pkg

// ---- frame_link.sv ----
// serial frame shifter running on the host's serial clock
// assumes i_tx_frame is stable while a frame runs; sync high clears the frame
`timescale 1ns/10ps
module frame_link
   import dac_ctrl_pkg::*;
(
   input wire logic i_sclk,
   input wire logic i_sync_n,
   input wire logic i_sdi,
   input wire frame_t i_tx_frame,
   output frame_t o_rx_frame,
   output logic o_rx_toggle,
   output logic o_sdo
);
   `include "dac_ctrl_params.svh"

   logic [4:0] bit_count_reg;
   logic started_reg;
   logic [31:0] shift_reg;
   // power-up value stands in for the reset that the link does not have
   logic toggle_reg = 1'b0;
   wire [31:0] shift_next = started_reg ? {shift_reg[30:0], i_sdi} : {i_tx_frame[30:0], i_sdi};
   wire word_done = ~i_sync_n & (bit_count_reg == `FRAME_LAST_BIT);

   // sclk stops between frames, so the frame's own sync ends the state
   always_ff @(negedge i_sclk or posedge i_sync_n)
   begin
      if (i_sync_n)
      begin
         bit_count_reg <= 5'h00;
         started_reg <= 1'b0;
         shift_reg <= 32'h0000_0000;
      end
      else
      begin
         bit_count_reg <= bit_count_reg + 5'h01;
         started_reg <= 1'b1;
         shift_reg <= shift_next; // RULE17
      end
   end

   // every 32nd bit hands a whole word across; extra clocks ripple on
   always_ff @(negedge i_sclk)
   begin
      if (word_done)
      begin
         o_rx_frame <= shift_next; // RULE17
         toggle_reg <= ~toggle_reg;
      end
   end

   always_ff @(posedge i_sclk or posedge i_sync_n)
   begin
      if (i_sync_n)
         o_sdo <= 1'b0;
      else
         o_sdo <= started_reg ? shift_reg[31] : i_tx_frame.dir; // RULE17
   end

   assign o_rx_toggle = toggle_reg;

endmodule : frame_link

// ---- spi_host_model.sv ----
// host side of the serial link: drives 32-bit frames on its own serial clock
// assumes the device samples sdi on falling sclk and drives sdo on rising sclk
`timescale 1ns/10ps
module spi_host_model
(
   output logic o_sclk,
   output logic o_sync_n,
   output logic o_sdi,
   input wire logic i_sdo
);
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      o_sclk = 1'b0;
      o_sync_n = 1'b1;
      o_sdi = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // one frame, msb first, 15 ns serial period; sclk stands low between frames
   task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
      o_sync_n = 1'b0;
      #7.5;
      for (int i = 31; i >= 0; i--)
      begin
         // sdi moves on the rising edge, half a period clear of the capture edge
         o_sclk = 1'b1;
         o_sdi = tx[i];
         #7.5;
         rx[i] = i_sdo;
         o_sclk = 1'b0;
         #7.5;
      end
      o_sync_n = 1'b1;
      // released line shows no stale bit
      o_sdi = ~o_sdi;
      // gap well above six core cycles so readback loads before the next frame
      #600;
   endtask : xfer
endmodule : spi_host_model

// ---- tb_dac_control_register_set.sv ----
// self-checking bench of the converter control registers with random config traffic
// assumes the host model owns the serial pins; core pins are driven at rising i_clock
`timescale 1ns/10ps
`include "dac_ctrl_params.svh"
module tb_dac_control_register_set;
   logic i_clock = 1'b0;
   logic i_nrst = 1'b0;
   logic clear_n = 1'b1;
   logic load_n = 1'b1;
   logic sclk, sync_n, sdi, sdo, sdo_oe_n, alarm_out, alarm_oe_n, fast_ro, settling, pd;
   logic tcal, th_dis, upd_src, clr_mode, upd, done;
   logic [3:0] span;
   logic [1:0] th_mask, rate;
   logic [7:0] clr_code;
   logic [23:0] c1, c2, d;
   int err_count = 0;
   int checked = 0;
   int upd_cnt = 0;
   int upd_ref = 0;
   wire [11:0] got1 = {tcal, th_mask, upd_src, fast_ro, settling, span, pd, sdo_oe_n};
   wire [11:0] exp1 = {c1[23], c1[19:18], c1[14], c1[13], c1[10], c1[9:6], c1[4], ~c1[11]};

   always #20 i_clock = ~i_clock;

   // pulses are counted so a later look cannot miss them
   always @(posedge i_clock)
      if (upd === 1'b1)
         upd_cnt <= upd_cnt + 1;

   spi_host_model host_u (.o_sclk(sclk), .o_sync_n(sync_n), .o_sdi(sdi), .i_sdo(sdo));

   dac_control_register_set #(.CAL_CYCLES(40)) dut_u
   (
      .i_clock(i_clock), .i_nrst(i_nrst), .i_sclk(sclk), .i_sync_n(sync_n), .i_sdi(sdi),
      .i_clear_input_n(clear_n), .i_load_strobe_n(load_n), .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n),
      .o_alarm_out(alarm_out), .o_alarm_oe_n(alarm_oe_n), .o_fast_readout_enable(fast_ro),
      .o_settling_mode_select(settling), .o_reference_span_select(span), .o_power_down_control(pd),
      .o_temperature_cal_enable(tcal), .o_track_hold_mask(th_mask), .o_track_hold_disable(th_dis),
      .o_update_rate(rate), .o_update_source_select(upd_src), .o_clear_code(clr_code),
      .o_clear_mode(clr_mode), .o_output_update(upd), .o_recalibration_done_flag(done)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (err_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // invalid span keeps the old one; mask is locked unless fast settling with track and hold
   function automatic logic [23:0] next_cfg1(input logic [23:0] o, input logic [23:0] w,
                                             input logic [23:0] t);
      logic [23:0] n;
      n = (o & ~`CFG1_WMASK) | (w & `CFG1_WMASK);
      if (w[`SPAN_HI:`SPAN_LO] < `SPAN_MIN_VALID)
         n[`SPAN_HI:`SPAN_LO] = o[`SPAN_HI:`SPAN_LO];
      if (o[`BIT_SETTLING] || t[`BIT_TH_DISABLE])
         n[`MASK_HI:`MASK_LO] = o[`MASK_HI:`MASK_LO];
      else
         n[`MASK_HI:`MASK_LO] = w[`MASK_HI:`MASK_LO];
      return n;
   endfunction : next_cfg1

   task automatic wr(input logic [6:0] a, input logic [23:0] v);
      logic [31:0] r;
      host_u.xfer({1'b0, a, v}, r);
   endtask : wr

   // answer to a read arrives in the following frame
   task automatic rdchk(input logic [6:0] a, input logic [23:0] v);
      logic [31:0] r;
      host_u.xfer({1'b1, a, 24'h00_0000}, r);
      host_u.xfer(32'h0000_0000, r);
      check(r, {1'b1, a, v});
   endtask : rdchk

   task automatic chk_ports();
      check({20'h0, got1}, {20'h0, exp1});
      check({29'h0, th_dis, rate}, {29'h0, c2[7], c2[5:4]});
   endtask : chk_ports

   function automatic logic probe(input int sel);
      case (sel)
         0: return clr_mode;
         1: return done;
         default: return upd_cnt != upd_ref;
      endcase
   endfunction : probe

   task automatic wait_for(input int sel);
      int n;
      n = 0;
      while (probe(sel) !== 1'b1 && n < 80)
      begin
         @(negedge i_clock);
         n++;
      end
      check({31'h0, probe(sel)}, 32'h0000_0001);
      if (probe(sel) !== 1'b1)
         give_verdict();
   endtask : wait_for

   task automatic strobe_load();
      @(posedge i_clock);
      load_n <= 1'b0;
      repeat (3) @(posedge i_clock);
      load_n <= 1'b1;
   endtask : strobe_load

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(32'hc346));
      repeat (8) @(posedge i_clock);
      i_nrst <= 1'b1;
      repeat (4) @(posedge i_clock);
      c1 = `CFG1_RESET;
      c2 = `CFG2_RESET;
      rdchk(`ADDR_CFG1, c1);
      rdchk(`ADDR_CFG2, c2);
      rdchk(`ADDR_CLEAR, 24'h00_0000);
      rdchk(`ADDR_STAT, 24'h00_0000);
      chk_ports();
      check({29'h0, alarm_out, alarm_oe_n, clr_mode}, 32'h0000_0002);
      for (int i = 0; i < 8; i++)
      begin
         c2 = (24'($urandom) & `CFG2_WMASK) | `CFG2_RESET;
         c2[5:4] = i[1:0];
         c2[`BIT_TH_DISABLE] = i[2];
         wr(`ADDR_CFG2, c2);
         // serial output kept on so readback stays possible
         d = (24'($urandom) & `CFG1_WMASK) | 24'h00_0800;
         // alternate settling so the mask is open in some rounds and locked in others
         d[`BIT_SETTLING] = i[0];
         d[`MASK_HI:`MASK_LO] = ~i[1:0];
         if (i < 3)
            d[9:6] = i[3:0];
         if (i == 3)
            d[9:6] = 4'hf;
         c1 = next_cfg1(c1, d, c2);
         wr(`ADDR_CFG1, d);
         rdchk(`ADDR_CFG1, c1);
         rdchk(`ADDR_CFG2, c2);
         chk_ports();
      end
      wr(7'h7f, 24'($urandom));
      rdchk(7'h7f, 24'h00_0000);
      d = 24'($urandom) & `CLEAR_WMASK;
      wr(`ADDR_CLEAR, d);
      rdchk(`ADDR_CLEAR, d);
      check({24'h0, clr_code}, {24'h0, d[23:16]});
      @(posedge i_clock);
      clear_n <= 1'b0;
      wait_for(0);
      @(posedge i_clock);
      clear_n <= 1'b1;
      repeat (4) @(posedge i_clock);
      wr(`ADDR_CFG2, c2);
      check({31'h0, clr_mode}, 32'h0000_0000);
      wr(`ADDR_TRIG, 24'h00_0020);
      wait_for(0);
      wr(`ADDR_CFG2, c2);
      check({31'h0, clr_mode}, 32'h0000_0000);
      d = c1 | 24'h00_4000;
      c1 = next_cfg1(c1, d, c2);
      wr(`ADDR_CFG1, d);
      upd_ref = upd_cnt;
      strobe_load();
      wait_for(2);
      d = c1 & ~24'h00_4000;
      c1 = next_cfg1(c1, d, c2);
      wr(`ADDR_CFG1, d);
      upd_ref = upd_cnt;
      strobe_load();
      repeat (10) @(posedge i_clock);
      check(32'(upd_cnt), 32'(upd_ref));
      wr(`ADDR_DATA, 24'($urandom) & 24'hff_fff0);
      wait_for(2);
      // serial output off: data update and soft clear act at sync rise
      d = c1 & ~24'h00_0800;
      c1 = next_cfg1(c1, d, c2);
      wr(`ADDR_CFG1, d);
      chk_ports();
      upd_ref = upd_cnt;
      wr(`ADDR_DATA, 24'($urandom) & 24'hff_fff0);
      wait_for(2);
      wr(`ADDR_TRIG, 24'h00_0020);
      wait_for(0);
      d = c1 | 24'h00_0800;
      c1 = next_cfg1(c1, d, c2);
      wr(`ADDR_CFG1, d);
      check({31'h0, clr_mode}, 32'h0000_0000);
      for (int k = 1; k >= 0; k--)
      begin
         d = c1 | 24'h80_0000;
         d[`BIT_ALARM_EN] = k[0];
         c1 = next_cfg1(c1, d, c2);
         wr(`ADDR_CFG1, d);
         wr(`ADDR_TRIG, 24'h00_0100);
         check({30'h0, done, alarm_oe_n}, 32'h0000_0001);
         wait_for(1);
         check({31'h0, alarm_oe_n}, {31'h0, ~k[0]});
         rdchk(`ADDR_STAT, 24'h00_1000);
         check({31'h0, alarm_oe_n}, 32'h0000_0001);
      end
      wr(`ADDR_TRIG, 24'h00_0000);
      rdchk(`ADDR_CFG1, c1);
      wr(`ADDR_TRIG, 24'h00_0040);
      c1 = `CFG1_RESET;
      c2 = `CFG2_RESET;
      rdchk(`ADDR_CFG1, c1);
      rdchk(`ADDR_CFG2, c2);
      rdchk(`ADDR_STAT, 24'h00_0000);
      chk_ports();
      give_verdict();
   end
endmodule : tb_dac_control_register_set
